// File: core/ref_status_regs.sv
// Reference slew status, status pin control and output mute level register bank.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Secondary rise/fall valid read-only, bits 7:6.
// - Primary rise/fall valid read-only, bits 5:4.
// - Bit 5 limits second flag pin spikes.
// - Bit 4 limits first flag pin spikes.
// - Bit 1 makes second pin open drain.
// - Bit 0 makes first pin open drain.
// - Four 2-bit mute level fields, reset 0x1.
// - Mute bit gates muting; level shapes.
// - Level 0 bypass; level 1 common mode when differential.
// - Level 2 force high when differential; level 3 rails.
module ref_status_regs
  import ref_status_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic secondary_rise_ok_i,
  input wire logic secondary_fall_ok_i,
  input wire logic primary_rise_ok_i,
  input wire logic primary_fall_ok_i,
  input wire logic first_flag_pin_i,
  input wire logic second_flag_pin_i,
  output logic first_flag_pin_o,
  output logic first_flag_pin_oe_n_o,
  output logic second_flag_pin_o,
  output logic second_flag_pin_oe_n_o,
  output logic first_flag_pin_spike_limit_o,
  output logic second_flag_pin_spike_limit_o,
  input wire logic [NUM_CH-1:0] silence_on_i,
  input wire logic [NUM_CH-1:0] diff_mode_i,
  output logic [2*NUM_CH-1:0] pos_node_o,
  output logic [2*NUM_CH-1:0] neg_node_o
);

  logic rst_meta_r;
  logic rst_sync_n_r;
  logic [DATA_W-1:0] pin_ctrl_r;
  logic [DATA_W-1:0] mute_level_r;
  logic [3:0] detect_r;
  logic [DATA_W-1:0] rdata_nxt;

  // Reset release goes through two flops so that deassertion is clean in our domain.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // Detector flags are captured each cycle so reads see the current state.
  always_ff @(posedge mclk_i or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      detect_r <= 4'h0;
    end else begin
      detect_r <= {secondary_rise_ok_i, secondary_fall_ok_i, primary_rise_ok_i, primary_fall_ok_i};
    end
  end

  // Status pin control keeps only its defined bits; reserved bits stay zero.
  always_ff @(posedge mclk_i or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      pin_ctrl_r <= PIN_CTRL_RESET;
    end else if (wr_i && addr_i == ADDR_PIN_CTRL) begin
      pin_ctrl_r <= wdata_i & PIN_CTRL_MASK;
    end
  end

  // Mute level register, all four channel fields writable.
  always_ff @(posedge mclk_i or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      mute_level_r <= MUTE_LEVEL_RESET;
    end else if (wr_i && addr_i == ADDR_MUTE_LEVEL) begin
      mute_level_r <= wdata_i;
    end
  end

  // Read mux; unmapped addresses answer zero.
  always_comb begin
    rdata_nxt = ZERO_BYTE;
    case (addr_i)
      ADDR_SLEW_STATUS: rdata_nxt = {detect_r, 4'h0};
      ADDR_PIN_CTRL: rdata_nxt = pin_ctrl_r;
      ADDR_MUTE_LEVEL: rdata_nxt = mute_level_r;
      default: rdata_nxt = ZERO_BYTE;
    endcase
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge mclk_i or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      rdata_o <= ZERO_BYTE;
    end else begin
      rdata_o <= rd_i ? rdata_nxt : ZERO_BYTE;
    end
  end

  // Status pin drivers: open drain only pulls low and releases for a high level.
  // Enables are active low; the pad resolves the wire from them.
  // In open drain mode a released pin shows whatever the board pull-up gives,
  // so a user who leaves the pull-up off sees a floating flag for every high level.
  // The spike limit bits are only handed to the pad; the slower edges that they
  // buy are a pad property and cost timing margin on the flag pins.
  always_ff @(posedge mclk_i or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      first_flag_pin_o <= 1'b0;
      first_flag_pin_oe_n_o <= 1'b0;
      second_flag_pin_o <= 1'b0;
      second_flag_pin_oe_n_o <= 1'b0;
      first_flag_pin_spike_limit_o <= 1'b0;
      second_flag_pin_spike_limit_o <= 1'b0;
    end else begin
      first_flag_pin_o <= pin_ctrl_r[BIT_FIRST_OD] ? 1'b0 : first_flag_pin_i;
      first_flag_pin_oe_n_o <= pin_ctrl_r[BIT_FIRST_OD] & first_flag_pin_i;
      second_flag_pin_o <= pin_ctrl_r[BIT_SECOND_OD] ? 1'b0 : second_flag_pin_i;
      second_flag_pin_oe_n_o <= pin_ctrl_r[BIT_SECOND_OD] & second_flag_pin_i;
      first_flag_pin_spike_limit_o <= pin_ctrl_r[BIT_FIRST_LIMIT];
      second_flag_pin_spike_limit_o <= pin_ctrl_r[BIT_SECOND_LIMIT];
    end
  end

  // Node action for the positive output of one channel.
  // The mute bit gates the level field, so a stored level never mutes on its own.
  function automatic logic [1:0] pos_action(input logic on, input logic diff, input logic [1:0] lvl);
    logic [1:0] act;
    act = NODE_NORMAL;
    if (on) begin
      case (lvl)
        LVL_BYPASS: act = NODE_NORMAL;
        LVL_COMMON_MODE: act = diff ? NODE_VCM : NODE_NORMAL;
        LVL_FORCE_HIGH: act = diff ? NODE_HIGH : NODE_LOW;
        LVL_RAILS: act = diff ? NODE_HIGH : NODE_LOW;
        default: act = NODE_NORMAL;
      endcase
    end
    return act;
  endfunction

  // Node action for the negative output of one channel.
  function automatic logic [1:0] neg_action(input logic on, input logic diff, input logic [1:0] lvl);
    logic [1:0] act;
    act = NODE_NORMAL;
    if (on) begin
      case (lvl)
        LVL_BYPASS: act = NODE_NORMAL;
        LVL_COMMON_MODE: act = diff ? NODE_VCM : NODE_LOW;
        LVL_FORCE_HIGH: act = diff ? NODE_LOW : NODE_NORMAL;
        LVL_RAILS: act = NODE_LOW;
        default: act = NODE_NORMAL;
      endcase
    end
    return act;
  endfunction

  // Per-channel driver action; a differential force high drives P high and N low.
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      always_ff @(posedge mclk_i or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
          pos_node_o[2*ch+:2] <= NODE_NORMAL;
          neg_node_o[2*ch+:2] <= NODE_NORMAL;
        end else begin
          pos_node_o[2*ch+:2] <= pos_action(silence_on_i[ch], diff_mode_i[ch], mute_level_r[LVL_W*ch+:LVL_W]);
          neg_node_o[2*ch+:2] <= neg_action(silence_on_i[ch], diff_mode_i[ch], mute_level_r[LVL_W*ch+:LVL_W]);
        end
      end

      // Each channel's mute shaping is checked where it is produced, except single-ended rails, which is checked below for channel 0 only.
      AST_CH_UNMUTED: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
        !silence_on_i[ch]
        |=> pos_node_o[2*ch+:2] == NODE_NORMAL && neg_node_o[2*ch+:2] == NODE_NORMAL)
        else $error("Unmuted channel left normal operation.");

      AST_BYPASS: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
        silence_on_i[ch] && mute_level_r[LVL_W*ch+:LVL_W] == LVL_BYPASS
        |=> pos_node_o[2*ch+:2] == NODE_NORMAL && neg_node_o[2*ch+:2] == NODE_NORMAL)
        else $error("Bypass level did not leave the channel running.");

      AST_CM_DIFF: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
        silence_on_i[ch] && diff_mode_i[ch] && mute_level_r[LVL_W*ch+:LVL_W] == LVL_COMMON_MODE
        |=> pos_node_o[2*ch+:2] == NODE_VCM && neg_node_o[2*ch+:2] == NODE_VCM)
        else $error("Differential level one did not go to common mode.");

      AST_CM_SE: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
        silence_on_i[ch] && !diff_mode_i[ch] && mute_level_r[LVL_W*ch+:LVL_W] == LVL_COMMON_MODE
        |=> pos_node_o[2*ch+:2] == NODE_NORMAL && neg_node_o[2*ch+:2] == NODE_LOW)
        else $error("Single-ended level one wrong.");

      AST_HIGH_DIFF: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
        silence_on_i[ch] && diff_mode_i[ch] && mute_level_r[LVL_W*ch+:LVL_W] == LVL_FORCE_HIGH
        |=> pos_node_o[2*ch+:2] == NODE_HIGH && neg_node_o[2*ch+:2] == NODE_LOW)
        else $error("Differential level two did not force high.");

      AST_HIGH_SE: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
        silence_on_i[ch] && !diff_mode_i[ch] && mute_level_r[LVL_W*ch+:LVL_W] == LVL_FORCE_HIGH
        |=> pos_node_o[2*ch+:2] == NODE_LOW && neg_node_o[2*ch+:2] == NODE_NORMAL)
        else $error("Single-ended level two wrong.");

      AST_RAILS_DIFF: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
        silence_on_i[ch] && diff_mode_i[ch] && mute_level_r[LVL_W*ch+:LVL_W] == LVL_RAILS
        |=> pos_node_o[2*ch+:2] == NODE_HIGH && neg_node_o[2*ch+:2] == NODE_LOW)
        else $error("Differential rails level wrong.");
    end
  endgenerate

  sequence s_status_read;
    rd_i && addr_i == ADDR_SLEW_STATUS;
  endsequence

  sequence s_pin_write;
    wr_i && addr_i == ADDR_PIN_CTRL;
  endsequence

  sequence s_pin_read;
    rd_i && addr_i == ADDR_PIN_CTRL;
  endsequence

  sequence s_mute_write;
    wr_i && addr_i == ADDR_MUTE_LEVEL;
  endsequence

  sequence s_mute_read;
    rd_i && addr_i == ADDR_MUTE_LEVEL;
  endsequence

  // An unmapped read must come back as zero, never as a stale register.
  sequence s_unmapped_read;
    rd_i && addr_i != ADDR_SLEW_STATUS && addr_i != ADDR_PIN_CTRL && addr_i != ADDR_MUTE_LEVEL;
  endsequence

  AST_SLEW_READ: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    s_status_read |=> rdata_o[7:4] == $past(detect_r) && rdata_o[3:0] == 4'h0)
    else $error("Slew status read returned wrong value.");
  AST_PRI_TRACK: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    1'b1 |=> detect_r[1:0] == $past({primary_rise_ok_i, primary_fall_ok_i}))
    else $error("Primary detector flags not tracked.");
  AST_SECOND_LIMIT: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    s_pin_write ##1 1'b1 |=> second_flag_pin_spike_limit_o == $past(wdata_i[BIT_SECOND_LIMIT], 2))
    else $error("Second pin spike limit not applied.");
  AST_FIRST_LIMIT: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    s_pin_write ##1 1'b1 |=> first_flag_pin_spike_limit_o == $past(wdata_i[BIT_FIRST_LIMIT], 2))
    else $error("First pin spike limit not applied.");
  AST_SECOND_OD: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    pin_ctrl_r[BIT_SECOND_OD] |=> !second_flag_pin_o)
    else $error("Second pin drove high in open drain mode.");
  AST_FIRST_PP: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    !pin_ctrl_r[BIT_FIRST_OD] |=> !first_flag_pin_oe_n_o && first_flag_pin_o == $past(first_flag_pin_i))
    else $error("First pin not push-pull.");
  AST_UNMUTED: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    !silence_on_i[3] |=> pos_node_o[7:6] == NODE_NORMAL && neg_node_o[7:6] == NODE_NORMAL)
    else $error("Unmuted channel not in normal operation.");
  AST_RAILS_SE: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    silence_on_i[0] && !diff_mode_i[0] && mute_level_r[1:0] == LVL_RAILS |=> pos_node_o[1:0] == NODE_LOW
    && neg_node_o[1:0] == NODE_LOW)
    else $error("Single-ended rails level wrong.");
  AST_RO_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    s_pin_write |=> pin_ctrl_r[7:6] == 2'h0 && pin_ctrl_r[3:2] == 2'h0)
    else $error("Reserved pin control bits took a write.");

  // Register bus checks.
  AST_MUTE_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    s_mute_write |=> mute_level_r == $past(wdata_i))
    else $error("Mute level write not stored.");
  AST_MUTE_READ: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    s_mute_read |=> rdata_o == $past(mute_level_r))
    else $error("Mute level read returned wrong value.");
  AST_PIN_READ: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    s_pin_read |=> rdata_o == $past(pin_ctrl_r))
    else $error("Pin control read returned wrong value.");
  AST_UNMAPPED_READ: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    s_unmapped_read |=> rdata_o == ZERO_BYTE)
    else $error("Unmapped read did not return zero.");
  AST_READ_IDLE: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    !rd_i |=> rdata_o == ZERO_BYTE)
    else $error("Read data stood without a read strobe.");

  // Detector and pin driver checks.
  AST_SEC_TRACK: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    1'b1 |=> detect_r[3:2] == $past({secondary_rise_ok_i, secondary_fall_ok_i}))
    else $error("Secondary detector flags not tracked.");
  AST_SECOND_PP: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    !pin_ctrl_r[BIT_SECOND_OD] |=> !second_flag_pin_oe_n_o && second_flag_pin_o == $past(second_flag_pin_i))
    else $error("Second pin not driven normally.");
  AST_FIRST_OD: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    pin_ctrl_r[BIT_FIRST_OD] |=> !first_flag_pin_o && first_flag_pin_oe_n_o == $past(first_flag_pin_i))
    else $error("First pin open drain release wrong.");
  AST_SECOND_RELEASE: assert property (@(posedge mclk_i) disable iff (!rst_sync_n_r)
    pin_ctrl_r[BIT_SECOND_OD] |=> second_flag_pin_oe_n_o == $past(second_flag_pin_i))
    else $error("Second pin open drain release wrong.");

endmodule // ref_status_regs
`default_nettype wire

// File: core/ref_status_pkg.sv
// Package with register map, field layout, reset values and mute encodings.
package ref_status_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_SLEW_STATUS = 8'h12;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h13;
  localparam logic [7:0] ADDR_MUTE_LEVEL = 8'h14;
  localparam int BIT_SEC_RISE = 7;
  localparam int BIT_SEC_FALL = 6;
  localparam int BIT_PRI_RISE = 5;
  localparam int BIT_PRI_FALL = 4;
  localparam int BIT_SECOND_LIMIT = 5;
  localparam int BIT_FIRST_LIMIT = 4;
  localparam int BIT_SECOND_OD = 1;
  localparam int BIT_FIRST_OD = 0;
  localparam logic [7:0] PIN_CTRL_MASK = 8'h33;
  localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
  localparam int NUM_CH = 4;
  localparam int LVL_W = 2;
  localparam logic [7:0] MUTE_LEVEL_RESET = 8'h55;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  typedef enum logic [1:0] {
    LVL_BYPASS = 2'h0,
    LVL_COMMON_MODE = 2'h1,
    LVL_FORCE_HIGH = 2'h2,
    LVL_RAILS = 2'h3
  } mute_level_e;
  // Driver action codes per output node.
  localparam logic [1:0] NODE_NORMAL = 2'h0;
  localparam logic [1:0] NODE_LOW = 2'h1;
  localparam logic [1:0] NODE_HIGH = 2'h2;
  localparam logic [1:0] NODE_VCM = 2'h3;
endpackage

// File: sim/ref_status_regs_bench.sv
// Self-checking bench for the reference status and mute level register bank.
`timescale 1ns/1ns
`default_nettype none
module ref_status_regs_bench;
  import ref_status_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] det = 4'h0;
  logic [1:0] pin_in = 2'h0;
  logic [3:0] sil = 4'h0;
  logic [3:0] dm = 4'h0;
  logic [7:0] rdata, pos, neg;
  logic f_o, f_oen, s_o, s_oen, f_lim, s_lim, ef, es;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] ctl [4] = '{8'h00, 8'h33, 8'h12, 8'h21};
  ref_status_regs ref_status_regs_i (.mclk_i(clk), .reset_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .secondary_rise_ok_i(det[3]), .secondary_fall_ok_i(det[2]),
    .primary_rise_ok_i(det[1]), .primary_fall_ok_i(det[0]), .first_flag_pin_i(pin_in[0]),
    .second_flag_pin_i(pin_in[1]), .first_flag_pin_o(f_o), .first_flag_pin_oe_n_o(f_oen),
    .second_flag_pin_o(s_o), .second_flag_pin_oe_n_o(s_oen), .first_flag_pin_spike_limit_o(f_lim),
    .second_flag_pin_spike_limit_o(s_lim), .silence_on_i(sil), .diff_mode_i(dm), .pos_node_o(pos),
    .neg_node_o(neg));
  // Clock at 125 MHz.
  always #4 clk = ~clk;
  // Cut a hang short; the whole run needs well under this many cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      final_report();
    end
  end
  task automatic final_report();
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-cycle write strobe; the strobe drops at the next edge.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  // Expected {pos, neg} node codes; an unmuted channel always runs normally.
  function automatic logic [3:0] node(input logic [1:0] l, input logic d, input logic m);
    if (!m || l == 2'h0) return {NODE_NORMAL, NODE_NORMAL};
    case (l)
      2'h1: return d ? {NODE_VCM, NODE_VCM} : {NODE_NORMAL, NODE_LOW};
      2'h2: return d ? {NODE_HIGH, NODE_LOW} : {NODE_LOW, NODE_NORMAL};
      default: return d ? {NODE_HIGH, NODE_LOW} : {NODE_LOW, NODE_LOW};
    endcase
  endfunction
  // Main sequence: reset values, detector reads, pin control, then every mute level.
  initial begin
    wait_clk(2);
    rst_n <= 1'b1;
    wait_clk(3);
    rd_chk(ADDR_SLEW_STATUS, 8'h00);
    rd_chk(ADDR_PIN_CTRL, 8'h00);
    rd_chk(ADDR_MUTE_LEVEL, 8'h55);
    rd_chk(8'h20, 8'h00);
    foreach (ctl[k]) begin
      det <= ctl[k][3:0] ^ 4'ha;
      wr_reg(ADDR_SLEW_STATUS, 8'hff);
      rd_chk(ADDR_SLEW_STATUS, {ctl[k][3:0] ^ 4'ha, 4'h0});
    end
    wr_reg(ADDR_PIN_CTRL, 8'hff);
    rd_chk(ADDR_PIN_CTRL, 8'h33);
    foreach (ctl[k]) begin
      wr_reg(ADDR_PIN_CTRL, ctl[k]);
      for (int p = 0; p < 4; p++) begin
        pin_in <= p[1:0];
        wait_clk(2);
        ef = ctl[k][0] & pin_in[0];
        es = ctl[k][1] & pin_in[1];
        check({2'h0, f_lim, s_lim, f_oen, s_oen, ef ? 1'b0 : f_o, es ? 1'b0 : s_o},
          {2'h0, ctl[k][4], ctl[k][5], ef, es, ctl[k][0] ? 1'b0 : pin_in[0],
          ctl[k][1] ? 1'b0 : pin_in[1]});
      end
    end
    for (int c = 0; c < 2; c++) begin
      dm <= 4'b0011;
      sil <= c == 0 ? 4'b0110 : 4'b1001;
      for (int l = 0; l < 4; l++) begin
        wr_reg(ADDR_MUTE_LEVEL, {4{l[1:0]}});
        wait_clk(1);
        for (int n = 0; n < NUM_CH; n++) begin
          check({4'h0, pos[2*n+:2], neg[2*n+:2]}, {4'h0, node(l[1:0], dm[n], sil[n])});
        end
        rd_chk(ADDR_MUTE_LEVEL, {4{l[1:0]}});
      end
    end
    final_report();
  end
endmodule // ref_status_regs_bench
`default_nettype wire
